// File: tssp_pkg.sv
// constants for the transceiver status and synchronisation pin block
package tssp_pkg;

   // -------------------------------------------------------------
   // register byte offsets (one aligned 32-bit word each)
   // -------------------------------------------------------------
   localparam logic [5:0] TSSP_OFS_ID      = 6'h00;
   localparam logic [5:0] TSSP_OFS_CTRL    = 6'h04;
   localparam logic [5:0] TSSP_OFS_IMASK   = 6'h08;
   localparam logic [5:0] TSSP_OFS_ISTAT   = 6'h0c;
   localparam logic [5:0] TSSP_OFS_ERRMASK = 6'h10;
   localparam logic [5:0] TSSP_OFS_STATUS  = 6'h14;

   // -------------------------------------------------------------
   // control register fields
   // -------------------------------------------------------------
   localparam int TSSP_CTL_RUN      = 0;
   localparam int TSSP_CTL_SYNC_OUT = 1;
   localparam int TSSP_CTL_INT_POL  = 2;
   localparam int TSSP_CTL_INT_OD   = 3;
   localparam int TSSP_CTL_RMCK256  = 4;
   localparam int TSSP_CTL_RATIO_LO = 5;
   localparam int TSSP_CTL_IN_MST   = 7;
   localparam int TSSP_CTL_OUT_MST  = 8;
   localparam int TSSP_CTL_W        = 9;
   localparam logic [8:0] TSSP_CTL_RST = 9'h004;

   // -------------------------------------------------------------
   // interrupt sources, receiver error sources, status fields
   // -------------------------------------------------------------
   localparam int TSSP_INT_W        = 3;
   localparam int TSSP_INT_RXFAULT  = 0;
   localparam int TSSP_INT_PREEMPH_FLAG_OUT     = 1;
   localparam int TSSP_INT_BLOCK    = 2;
   localparam int TSSP_ERR_W        = 7;  // validity,parity,biphase,conf,subcode_crc_err,chanstat_crc_err,unlock
   localparam int TSSP_ID_LSB       = 0;
   localparam int TSSP_REV_LSB      = 4;
   localparam int TSSP_ST_FAULT     = 7;
   localparam int TSSP_ST_PREEMPH_FLAG_OUT      = 8;
   localparam int TSSP_ST_ADDR2     = 9;
   localparam int TSSP_ST_INT       = 10;

   // -------------------------------------------------------------
   // stream encodings and timing counts
   // -------------------------------------------------------------
   localparam logic [2:0] TSSP_PREEMPH_FLAG_OUT_50_15    = 3'h4;
   localparam logic [1:0] TSSP_RATIO_256     = 2'h0;
   localparam logic [1:0] TSSP_RATIO_384     = 2'h1;
   localparam logic [1:0] TSSP_RATIO_512     = 2'h2;
   localparam int         TSSP_SYNC_MIN_CYC  = 3;    // encoder clocks
   localparam int         TSSP_BLOCK_SUBFR   = 384;  // 192 frames of two sub-frames
   localparam int         TSSP_RCV_TICKS_FS  = 512;  // recovered ticks per input sample

   typedef enum logic [0:0] {TSSP_BOOT = 1'b0, TSSP_LIVE = 1'b1} tssp_phase_e;
endpackage

// File: tssp_top.sv
// device-side status, interrupt, start-up and block sync pin logic
//
// Contract
// RULE1: readable fixed 4-bit identification code
// RULE2: readable fixed 4-bit revision code
// RULE3: shared clocks and reset release align ports; code starts the dividers only once run is set
// RULE4: synced output ports: all slave or one master
// RULE5: exactly one block sync master, rest slaves
// RULE6: output master clock is 256/384/512 times rate
// RULE7: recovered master clock at 128x or 256x
// RULE8: word clocks toggle at their port sample rate
// RULE9: reset gives low power and initial state
// RULE10: hold reset until supplies, clocks stable
// RULE11: interrupt sources maskable, causes readable
// RULE12: interrupt polarity and open-drain selectable
// RULE13: interrupt drops after status read and clear
// RULE14: receiver fault high, updated per sub-frame
// RULE15: seven receiver error conditions raise fault
// RULE16: each fault condition individually maskable
// RULE17: fault tracks unmasked errors immediately; code updates it only at each sub-frame strobe
// RULE18: emphasis flag low only for 50/15
// RULE19: emphasis pin strap sets address bit two
// RULE20: sync output high during first sub-frame
// RULE21: sync input three clocks starts next block
// RULE22: line drivers low while in reset
// RULE23: strap pins sampled at reset exit
// RULE24: sync pin role written while stopped
`timescale 1ns/1ps
module tssp_top
   import tssp_pkg::*;
#(
   parameter logic [3:0] ID_CODE  = 4'h5,  // arbitrary value
   parameter logic [3:0] REV_CODE = 4'h2   // arbitrary value
)(
   input  wire logic                  i_mclk,
   input  wire logic                  i_srst,
   input  wire logic [5:0]            i_avs_address,
   input  wire logic                  i_avs_read,
   input  wire logic                  i_avs_write,
   input  wire logic [31:0]           i_avs_writedata,
   output logic      [31:0]           o_avs_readdata,
   output logic                       o_avs_waitrequest,
   input  wire logic [TSSP_ERR_W-1:0] i_rx_err_flags,
   input  wire logic                  i_rx_subframe_stb,
   input  wire logic [2:0]            i_preemph_flag_out_code,
   input  wire logic                  i_preemph_flag_out_valid,
   input  wire logic                  i_preemph_pin,
   output logic                       o_preemph_flag_out,
   output logic                       o_preemph_oe,
   output logic                       o_ctrl_addr_bit2,
   output logic                       o_rx_fault_out,
   output logic                       o_int_pin,
   output logic                       o_int_oe,
   input  wire logic                  i_tx_subframe_stb,
   input  wire logic                  i_cs_block_sync,
   output logic                       o_cs_block_sync,
   output logic                       o_cs_block_sync_oe,
   input  wire logic                  i_tx_line_data,
   output logic                       o_line_drv_pos,
   output logic                       o_line_drv_neg,
   input  wire logic                  i_rcv_tick,
   input  wire logic                  i_out_master_clk_tick,
   output logic                       o_recovered_master_clk,
   output logic                       o_in_word_clk,
   output logic                       o_in_word_oe,
   output logic                       o_out_word_clk,
   output logic                       o_out_word_oe,
   output logic                       o_low_power
);

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   // half a word period in output master clock ticks
   function automatic logic [8:0] ratio_half(input logic [1:0] sel);
      case (sel)
         TSSP_RATIO_384: ratio_half = 9'h0c0;
         TSSP_RATIO_512: ratio_half = 9'h100;
         default:        ratio_half = 9'h080;
      endcase
   endfunction

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic [TSSP_CTL_W-1:0] ctl_q, ctl_d;
   logic [TSSP_INT_W-1:0] imask_q, imask_d, istat_q, istat_d;
   logic [TSSP_ERR_W-1:0] errmask_q, errmask_d;
   logic [31:0]           rdata_q, rdata_d;
   logic                  wait_q, wait_d;
   tssp_phase_e           phase_q, phase_d;
   logic                  addr2_q, addr2_d, fault_q, fault_d, preemph_flag_out_q, preemph_flag_out_d;
   logic                  int_act_q, int_act_d, rd_seen_q, rd_seen_d;
   logic                  intpin_q, intpin_d, intoe_q, intoe_d;
   logic [1:0]            hi_cnt_q, hi_cnt_d;
   logic                  pend_q, pend_d, sync_q, sync_d;
   logic [8:0]            idx_q, idx_d;
   logic                  drvp_q, drvp_d, drvn_q, drvn_d;
   logic [8:0]            rcnt_q, rcnt_d, ocnt_q, ocnt_d;
   logic                  recovered_master_clk_q, recovered_master_clk_d, iwc_q, iwc_d, owc_q, owc_d;
   logic [TSSP_INT_W-1:0] ev;
   logic                  acc, wr_acc, rd_acc, run;

   assign run    = ctl_q[TSSP_CTL_RUN];
   assign acc    = (i_avs_read | i_avs_write) & ~wait_q;
   assign wr_acc = acc & i_avs_write;
   assign rd_acc = acc & i_avs_read;

   // -------------------------------------------------------------
   // avalon slave: one wait cycle, read data staged meanwhile
   // -------------------------------------------------------------
   always_comb
   begin
      wait_d    = ~((i_avs_read | i_avs_write) & wait_q);
      rdata_d   = rdata_q;
      ctl_d     = ctl_q;
      imask_d   = imask_q;
      errmask_d = errmask_q;
      if ((i_avs_read | i_avs_write) & wait_q)
      begin
         rdata_d = 32'h0;  // unmapped offsets read zero
         case (i_avs_address)
            TSSP_OFS_ID:
            begin
               rdata_d[TSSP_ID_LSB +: 4]  = ID_CODE;   // [RULE1]
               rdata_d[TSSP_REV_LSB +: 4] = REV_CODE;  // [RULE2]
            end
            TSSP_OFS_CTRL:    rdata_d[TSSP_CTL_W-1:0] = ctl_q;
            TSSP_OFS_IMASK:   rdata_d[TSSP_INT_W-1:0] = imask_q;
            // an event in the staging cycle is shown too, since the accept clears it
            TSSP_OFS_ISTAT:   rdata_d[TSSP_INT_W-1:0] = istat_q | (ev & imask_q);  // [RULE11]
            TSSP_OFS_ERRMASK: rdata_d[TSSP_ERR_W-1:0] = errmask_q;
            TSSP_OFS_STATUS:
            begin
               rdata_d[TSSP_ERR_W-1:0] = i_rx_err_flags;
               rdata_d[TSSP_ST_FAULT]  = fault_q;
               rdata_d[TSSP_ST_PREEMPH_FLAG_OUT]   = preemph_flag_out_q;
               rdata_d[TSSP_ST_ADDR2]  = addr2_q;
               rdata_d[TSSP_ST_INT]    = int_act_q;
            end
            default: rdata_d = 32'h0;
         endcase
      end
      if (wr_acc)
      begin
         case (i_avs_address)
            TSSP_OFS_CTRL:
            begin
               ctl_d = i_avs_writedata[TSSP_CTL_W-1:0];
               // role only changes while stopped [RULE24]
               if (run)
                  ctl_d[TSSP_CTL_SYNC_OUT] = ctl_q[TSSP_CTL_SYNC_OUT];
            end
            TSSP_OFS_IMASK:   imask_d   = i_avs_writedata[TSSP_INT_W-1:0];  // [RULE11]
            TSSP_OFS_ERRMASK: errmask_d = i_avs_writedata[TSSP_ERR_W-1:0];  // [RULE16]
            default:          ctl_d     = ctl_q;
         endcase
      end
   end

   // -------------------------------------------------------------
   // receiver fault, emphasis, strap, sync and interrupt logic
   // -------------------------------------------------------------
   always_comb
   begin
      // strap is read on the first edge after reset, then pin drives [RULE19] [RULE23]
      phase_d = TSSP_LIVE;
      addr2_d = (phase_q == TSSP_BOOT) ? i_preemph_pin : addr2_q;
      // only re-evaluated per sub-frame, so a glitch between frames is unseen
      fault_d = i_rx_subframe_stb ? |(i_rx_err_flags & ~errmask_q) : fault_q;  // [RULE14] [RULE15] [RULE17]
      preemph_flag_out_d  = preemph_flag_out_q;
      if (i_preemph_flag_out_valid)
         preemph_flag_out_d = (i_preemph_flag_out_code != TSSP_PREEMPH_FLAG_OUT_50_15);  // [RULE18]
      // block sync input: three high clocks arm a block restart [RULE21]
      hi_cnt_d = i_cs_block_sync ? ((hi_cnt_q == 2'(TSSP_SYNC_MIN_CYC)) ? hi_cnt_q
                                                                      : hi_cnt_q + 2'h1)
                                 : 2'h0;
      pend_d   = pend_q;
      if (!ctl_q[TSSP_CTL_SYNC_OUT] && hi_cnt_d == 2'(TSSP_SYNC_MIN_CYC))
         pend_d = 1'b1;
      idx_d = idx_q;
      if (run && i_tx_subframe_stb)
      begin
         if (pend_q || idx_q == 9'(TSSP_BLOCK_SUBFR - 1))
            idx_d = 9'h0;
         else
            idx_d = idx_q + 9'h1;
         pend_d = 1'b0;
      end
      sync_d = (idx_d == 9'h0) & run;  // [RULE20]
      // interrupt events
      ev                  = '0;
      ev[TSSP_INT_RXFAULT] = fault_d & ~fault_q;
      ev[TSSP_INT_PREEMPH_FLAG_OUT]    = preemph_flag_out_d ^ preemph_flag_out_q;
      ev[TSSP_INT_BLOCK]   = run & i_tx_subframe_stb & (idx_d == 9'h0);
      // read clears the status, a new event in the same cycle survives
      istat_d = istat_q;
      if (rd_acc && i_avs_address == TSSP_OFS_ISTAT)
         istat_d = '0;
      istat_d = istat_d | (ev & imask_q);  // [RULE11]
      rd_seen_d = rd_seen_q | (rd_acc && i_avs_address == TSSP_OFS_ISTAT);
      int_act_d = int_act_q;
      if (!int_act_q && |istat_d)
      begin
         int_act_d = 1'b1;
         rd_seen_d = 1'b0;
      end
      else if (int_act_q && rd_seen_q && istat_q == '0)
         int_act_d = 1'b0;  // [RULE13]
      // pin drive per polarity and output type [RULE12]
      if (ctl_q[TSSP_CTL_INT_OD])
      begin
         intpin_d = 1'b0;
         intoe_d  = int_act_d;
      end
      else
      begin
         intpin_d = int_act_d ~^ ctl_q[TSSP_CTL_INT_POL];
         intoe_d  = 1'b1;
      end
      // drivers idle low until running [RULE22]
      drvp_d = run & i_tx_line_data;
      drvn_d = run & ~i_tx_line_data;
   end

   // -------------------------------------------------------------
   // clock outputs from enable ticks
   // -------------------------------------------------------------
   always_comb
   begin
      rcnt_d = rcnt_q;
      recovered_master_clk_d = recovered_master_clk_q;
      iwc_d  = iwc_q;
      if (run && i_rcv_tick)
      begin
         rcnt_d = rcnt_q + 9'h1;
         // 128x needs every second tick, 256x every tick [RULE7]
         if (ctl_q[TSSP_CTL_RMCK256] || rcnt_q[0])
            recovered_master_clk_d = ~recovered_master_clk_q;
         if (rcnt_q == 9'(TSSP_RCV_TICKS_FS / 2 - 1))
            rcnt_d = 9'h0;
         if (rcnt_q == 9'(TSSP_RCV_TICKS_FS / 2 - 1))
            iwc_d = ~iwc_q;  // [RULE8]
      end
      ocnt_d = ocnt_q;
      owc_d  = owc_q;
      // dividers clear in reset and start counting when run is set, so parts sharing reset and run line up [RULE3]
      if (run && i_out_master_clk_tick)
      begin
         if (ocnt_q >= ratio_half(ctl_q[TSSP_CTL_RATIO_LO +: 2]) - 9'h1)
         begin
            ocnt_d = 9'h0;
            owc_d  = ~owc_q;  // [RULE6] [RULE8]
         end
         else
            ocnt_d = ocnt_q + 9'h1;
      end
   end

   // -------------------------------------------------------------
   // registers; reset returns everything to idle [RULE9]
   // -------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         ctl_q     <= TSSP_CTL_RST;
         imask_q   <= '0;
         istat_q   <= '0;
         errmask_q <= '0;
         rdata_q   <= 32'h0;
         wait_q    <= 1'b1;
         phase_q   <= TSSP_BOOT;
         addr2_q   <= 1'b0;
         fault_q   <= 1'b1;  // flagged until first clean sub-frame
         preemph_flag_out_q    <= 1'b1;
         int_act_q <= 1'b0;
         rd_seen_q <= 1'b0;
         intpin_q  <= 1'b0;
         intoe_q   <= 1'b0;
         hi_cnt_q  <= 2'h0;
         pend_q    <= 1'b0;
         sync_q    <= 1'b0;
         idx_q     <= 9'h0;
         drvp_q    <= 1'b0;
         drvn_q    <= 1'b0;
         rcnt_q    <= 9'h0;
         ocnt_q    <= 9'h0;
         recovered_master_clk_q    <= 1'b0;
         iwc_q     <= 1'b0;
         owc_q     <= 1'b0;
      end
      else
      begin
         ctl_q     <= ctl_d;
         imask_q   <= imask_d;
         istat_q   <= istat_d;
         errmask_q <= errmask_d;
         rdata_q   <= rdata_d;
         wait_q    <= wait_d;
         phase_q   <= phase_d;
         addr2_q   <= addr2_d;
         fault_q   <= fault_d;
         preemph_flag_out_q    <= preemph_flag_out_d;
         int_act_q <= int_act_d;
         rd_seen_q <= rd_seen_d;
         intpin_q  <= intpin_d;
         intoe_q   <= intoe_d;
         hi_cnt_q  <= hi_cnt_d;
         pend_q    <= pend_d;
         sync_q    <= sync_d;
         idx_q     <= idx_d;
         drvp_q    <= drvp_d;
         drvn_q    <= drvn_d;
         rcnt_q    <= rcnt_d;
         ocnt_q    <= ocnt_d;
         recovered_master_clk_q    <= recovered_master_clk_d;
         iwc_q     <= iwc_d;
         owc_q     <= owc_d;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign o_avs_readdata         = rdata_q;
   assign o_avs_waitrequest      = wait_q;
   assign o_preemph_flag_out     = preemph_flag_out_q;
   assign o_preemph_oe           = (phase_q == TSSP_LIVE);
   assign o_ctrl_addr_bit2       = addr2_q;
   assign o_rx_fault_out         = fault_q;
   assign o_int_pin              = intpin_q;
   assign o_int_oe               = intoe_q;
   assign o_cs_block_sync        = sync_q;
   assign o_cs_block_sync_oe     = ctl_q[TSSP_CTL_SYNC_OUT];  // [RULE5]
   assign o_line_drv_pos         = drvp_q;
   assign o_line_drv_neg         = drvn_q;
   assign o_recovered_master_clk = recovered_master_clk_q;
   assign o_in_word_clk          = iwc_q;
   assign o_in_word_oe           = ctl_q[TSSP_CTL_IN_MST];
   assign o_out_word_clk         = owc_q;
   assign o_out_word_oe          = ctl_q[TSSP_CTL_OUT_MST];  // [RULE4]
   assign o_low_power            = ~run;

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   property p_id_read;
      (i_avs_read && wait_q && i_avs_address == TSSP_OFS_ID)
         |=> !o_avs_waitrequest && o_avs_readdata[3:0] == ID_CODE;
   endproperty
   a_id_read: assert property (p_id_read) else $error("id code wrong");  // [RULE1]

   property p_rev_read;
      (i_avs_read && wait_q && i_avs_address == TSSP_OFS_ID)
         |=> o_avs_readdata[7:4] == REV_CODE;
   endproperty
   a_rev_read: assert property (p_rev_read) else $error("revision wrong");  // [RULE2]

   property p_lines_idle;
      !run |=> !o_line_drv_pos && !o_line_drv_neg;
   endproperty
   a_lines_idle: assert property (p_lines_idle) else $error("driver active when stopped");  // [RULE22]

   property p_fault;
      i_rx_subframe_stb |=> o_rx_fault_out == $past(|(i_rx_err_flags & ~errmask_q));
   endproperty
   a_fault: assert property (p_fault) else $error("fault level wrong");  // [RULE17]

   property p_preemph_flag_out;
      (i_preemph_flag_out_valid && i_preemph_flag_out_code == TSSP_PREEMPH_FLAG_OUT_50_15) |=> !o_preemph_flag_out;
   endproperty
   a_preemph_flag_out: assert property (p_preemph_flag_out) else $error("emphasis flag wrong");  // [RULE18]

   property p_sync_out;
      (run && i_tx_subframe_stb && idx_q == 9'(TSSP_BLOCK_SUBFR - 1)) |=> o_cs_block_sync;
   endproperty
   a_sync_out: assert property (p_sync_out) else $error("block start missed");  // [RULE20]

   property p_sync_in;
      (!ctl_q[TSSP_CTL_SYNC_OUT] && run && i_cs_block_sync [*3] ##1 i_tx_subframe_stb)
         |=> idx_q == 9'h0;
   endproperty
   a_sync_in: assert property (p_sync_in) else $error("input sync ignored");  // [RULE21]

   property p_int_fall;
      $fell(int_act_q) |-> $past(rd_seen_q) && $past(istat_q) == '0;
   endproperty
   a_int_fall: assert property (p_int_fall) else $error("interrupt dropped early");  // [RULE13]

   property p_role_hold;
      (run && wr_acc && i_avs_address == TSSP_OFS_CTRL) |=> $stable(o_cs_block_sync_oe);
   endproperty
   a_role_hold: assert property (p_role_hold) else $error("role changed while running");  // [RULE24]

   property p_strap;
      $rose(o_preemph_oe) |-> o_ctrl_addr_bit2 == $past(i_preemph_pin);
   endproperty
   a_strap: assert property (p_strap) else $error("strap not sampled");  // [RULE23]

   c_int:   cover property (int_act_q && rd_seen_q);
   c_sync:  cover property (pend_q && i_tx_subframe_stb);
   c_fault: cover property ($fell(o_rx_fault_out));
endmodule

// File: tssp_far_model.sv
// far-side model: sub-frame strobes, block sync pin driver, strap pull
`timescale 1ns/1ps
module tssp_far_model
#(
   parameter int   RX_PER = 8,
   parameter int   TX_PER = 4,
   parameter logic PULL   = 1'b1
)(
   input  wire logic i_mclk,
   input  wire logic i_sync_req,
   input  wire logic i_flag_out,
   input  wire logic i_flag_oe,
   output logic      o_rx_stb,
   output logic      o_tx_stb,
   output logic      o_sync_pin,
   output logic      o_preemph_flag_out_pin
);
   int rx_cnt = 0;
   int tx_cnt = 0;
   int hold   = 0;
   // -----------------------------------------------------------
   // stream timing and pin levels
   // -----------------------------------------------------------
   // strap resistor shows only while the device leaves the pin
   assign o_preemph_flag_out_pin = i_flag_oe ? i_flag_out : PULL;
   assign o_sync_pin = (hold > 0);
   // strobes run through reset, like a live stream would
   always @(posedge i_mclk)
   begin
      rx_cnt   <= (rx_cnt + 1) % RX_PER;
      tx_cnt   <= (tx_cnt + 1) % TX_PER;
      o_rx_stb <= (rx_cnt == 0);
      o_tx_stb <= (tx_cnt == 0);
      if (i_sync_req && hold == 0)
         hold <= 3;  // minimum high time, no margin
      else if (hold > 0)
         hold <= hold - 1;
   end
endmodule

// File: tssp_tb_top.sv
// self-checking bench for the status and block sync pin block
`timescale 1ns/1ps
module tssp_tb_top
   import tssp_pkg::*;
;
   localparam logic [3:0] ID_V  = 4'h9; // arbitrary value
   localparam logic [3:0] REV_V = 4'h3; // arbitrary value
   localparam int         TX_P  = 4;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [5:0]  adr = 6'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [6:0]  flags = 7'h00;
   logic [2:0]  ecode = 3'h0;
   logic        evld = 1'b0;
   logic        sreq = 1'b0;
   logic        txd = 1'b0;
   logic        tick = 1'b1;
   logic [31:0] rdat;
   logic [31:0] w_rdat;
   logic        w_wait, w_flag, w_poe, w_a2, w_fault, w_int, w_ioe;
   logic        w_sync, w_soe, w_pos, w_neg, w_recovered_master_clk, w_low;
   logic        w_iwc, w_iwoe, w_owc, w_owoe;
   logic        rx_stb, tx_stb, spin, epin;
   int          bad_count = 0;
   int          n_compared = 0;
   int          m, n;

   always #25 clk = ~clk;

   tssp_top #(.ID_CODE(ID_V), .REV_CODE(REV_V)) u_dut (
      .i_mclk(clk), .i_srst(rst), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(w_rdat),
      .o_avs_waitrequest(w_wait), .i_rx_err_flags(flags), .i_rx_subframe_stb(rx_stb),
      .i_preemph_flag_out_code(ecode), .i_preemph_flag_out_valid(evld), .i_preemph_pin(epin),
      .o_preemph_flag_out(w_flag), .o_preemph_oe(w_poe), .o_ctrl_addr_bit2(w_a2),
      .o_rx_fault_out(w_fault), .o_int_pin(w_int), .o_int_oe(w_ioe),
      .i_tx_subframe_stb(tx_stb), .i_cs_block_sync(spin), .o_cs_block_sync(w_sync),
      .o_cs_block_sync_oe(w_soe), .i_tx_line_data(txd), .o_line_drv_pos(w_pos),
      .o_line_drv_neg(w_neg), .i_rcv_tick(tick), .i_out_master_clk_tick(tick),
      .o_recovered_master_clk(w_recovered_master_clk), .o_in_word_clk(w_iwc), .o_in_word_oe(w_iwoe),
      .o_out_word_clk(w_owc), .o_out_word_oe(w_owoe), .o_low_power(w_low));

   tssp_far_model #(.TX_PER(TX_P)) u_far (
      .i_mclk(clk), .i_sync_req(sreq), .i_flag_out(w_flag), .i_flag_oe(w_poe),
      .o_rx_stb(rx_stb), .o_tx_stb(tx_stb), .o_sync_pin(spin), .o_preemph_flag_out_pin(epin));

   // -----------------------------------------------------------
   // tasks
   // -----------------------------------------------------------
   task complete_run;
      if (bad_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // one access; request held until waitrequest is sampled low at a rising edge
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d,
            output logic [31:0] q);
      logic done;
      done = 1'b0;
      @(posedge clk);
      adr  <= a;
      wdat <= d;
      rd   <= ~w;
      wr   <= w;
      while (!done)
      begin
         // look mid-cycle, where the answer has settled for the coming edge
         @(negedge clk);
         done = (w_wait === 1'b0);
         q    = w_rdat;
         @(posedge clk);
      end
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task tog(input logic [31:0] e);
      int k;
      logic p;
      k = 0;
      @(negedge clk);
      p = w_recovered_master_clk;
      repeat (16)
      begin
         @(negedge clk);
         k += (w_recovered_master_clk !== p);
         p = w_recovered_master_clk;
      end
      chk(k, e);
   endtask

   // cycles between two word clock toggles, after lining up on one
   task half(input logic s, output int k);
      logic p;
      @(negedge clk);
      repeat (2)
      begin
         k = 0;
         p = s ? w_iwc : w_owc;
         while ((s ? w_iwc : w_owc) === p && k < 1000)
         begin
            @(negedge clk);
            k++;
         end
      end
   endtask

   // cycles until the sync pin shows v; bounded by a block and then some
   task wait_sync(input logic v, output int k);
      k = 0;
      while (w_sync !== v && k < 4000)
      begin
         @(negedge clk);
         k++;
      end
   endtask

   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      chk({30'h0, w_pos, w_neg}, 32'h0);
      chk({30'h0, w_low, w_poe}, 32'h2);
      rst <= 1'b0;
      cyc(3);
      chk({31'h0, w_a2}, 32'h1);
      bus(0, TSSP_OFS_ID, 0, rdat);
      chk(rdat, {24'h0, REV_V, ID_V});
      bus(0, TSSP_OFS_CTRL, 0, rdat);
      chk(rdat, 32'h4);
      bus(0, 6'h18, 0, rdat);
      chk(rdat, 32'h0);
      bus(1, TSSP_OFS_IMASK, 0, rdat);
      // each error alone, blocked only by its own mask bit
      for (int i = 0; i < 7; i++)
      begin
         flags <= 7'h1 << i;
         bus(1, TSSP_OFS_ERRMASK, 32'h7f ^ (32'h1 << i), rdat);
         cyc(20);
         chk({31'h0, w_fault}, 32'h1);
         bus(1, TSSP_OFS_ERRMASK, 32'h7f, rdat);
         cyc(20);
         chk({31'h0, w_fault}, 32'h0);
      end
      bus(0, TSSP_OFS_ISTAT, 0, rdat);
      chk(rdat, 32'h0);
      flags <= 7'h0;
      bus(1, TSSP_OFS_ERRMASK, 32'h0, rdat);
      bus(1, TSSP_OFS_IMASK, 32'h1, rdat);
      cyc(20);
      flags <= 7'h40;
      cyc(20);
      flags <= 7'h0;
      cyc(20);
      chk({30'h0, w_int, w_ioe}, 32'h3);
      bus(0, TSSP_OFS_ISTAT, 0, rdat);
      chk(rdat, 32'h1);
      cyc(4);
      chk({30'h0, w_int, w_ioe}, 32'h1);
      bus(1, TSSP_OFS_CTRL, 32'h0, rdat);
      cyc(3);
      chk({30'h0, w_int, w_ioe}, 32'h3);
      bus(1, TSSP_OFS_CTRL, 32'h8, rdat);
      cyc(3);
      chk({30'h0, w_int, w_ioe}, 32'h0);
      for (int c = 0; c < 8; c++)
      begin
         ecode <= c[2:0];
         evld  <= 1'b1;
         cyc(1);
         evld  <= 1'b0;
         cyc(3);
         chk({31'h0, w_flag}, {31'h0, c[2:0] != TSSP_PREEMPH_FLAG_OUT_50_15});
      end
      // sync role is set while stopped, then must survive a running write
      bus(1, TSSP_OFS_CTRL, 32'h16, rdat);
      bus(1, TSSP_OFS_CTRL, 32'h17, rdat);
      bus(1, TSSP_OFS_CTRL, 32'h15, rdat);
      bus(0, TSSP_OFS_CTRL, 0, rdat);
      chk(rdat, 32'h17);
      txd <= 1'b1;
      cyc(3);
      chk({29'h0, w_low, w_pos, w_neg}, 32'h2);
      tog(32'd16);
      wait_sync(1, n);
      wait_sync(0, n);
      wait_sync(1, m);
      wait_sync(0, n);
      chk(m + n, TSSP_BLOCK_SUBFR * TX_P);
      chk(n, TX_P);
      chk({31'h0, w_soe}, 32'h1);
      chk({30'h0, w_iwoe, w_owoe}, 32'h0);
      half(1'b1, n);
      chk(n, TSSP_RCV_TICKS_FS / 2);
      half(1'b0, n);
      chk(n, 256 / 2);
      bus(1, TSSP_OFS_CTRL, 32'h1b7, rdat);
      cyc(1);
      chk({30'h0, w_iwoe, w_owoe}, 32'h3);
      half(1'b0, n);
      chk(n, 384 / 2);
      bus(1, TSSP_OFS_CTRL, 32'h07, rdat);
      tog(32'd8);
      bus(1, TSSP_OFS_CTRL, 32'h04, rdat);
      bus(1, TSSP_OFS_CTRL, 32'h05, rdat);
      bus(1, TSSP_OFS_IMASK, 32'h4, rdat);
      bus(0, TSSP_OFS_ISTAT, 0, rdat);
      sreq <= 1'b1;
      cyc(1);
      sreq <= 1'b0;
      cyc(12);
      chk({31'h0, w_soe}, 32'h0);
      bus(0, TSSP_OFS_ISTAT, 0, rdat);
      chk(rdat & 32'h4, 32'h4);
      complete_run;
   end

   // hang guard, well beyond the few thousand cycles the sequence needs
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      complete_run;
   end
endmodule
